// ==== line_xfer_pkg.sv ====
`default_nettype none
package line_xfer_pkg;
	localparam int LINES = 16;
	localparam int WORDS = 256;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] REG_TXP_ADDR = 4'h0;
	localparam logic [3:0] REG_TXP_CNT = 4'h1;
	localparam logic [3:0] REG_TXA_ADDR = 4'h2;
	localparam logic [3:0] REG_TXA_CNT = 4'h3;
	localparam logic [3:0] REG_RX_ADDR = 4'h4;
	localparam logic [3:0] REG_RX_CNT = 4'h5;
	localparam logic [3:0] REG_TX_ACC = 4'h6;
	localparam logic [3:0] REG_RX_ACC = 4'h7;
	localparam logic [3:0] REG_TX_TAB = 4'h8;
	localparam logic [3:0] REG_RX_TAB = 4'h9;
	localparam int MARK_BIT = 15;
	localparam int SCR_EXT_LO = 4;
	localparam int CTRL_CHECK_BIT = 3;
	localparam int LS_GO_BIT = 2;
	localparam int LS_ALT_BIT = 7;
	localparam int LS_CHECK_BIT = 10;
	localparam int LS_MODE_LO = 13;
	localparam int LP_CHECK_BIT = 10;
	localparam int LP_MODE_LO = 13;
	localparam int PP_TYPE_LO = 3;
	localparam logic [1:0] CHK_LRC = 2'h0;
	localparam logic [1:0] CHK_CRC16 = 2'h1;
	localparam logic [1:0] CHK_CCITT = 2'h3;
	localparam logic [15:0] CRC16_POLY = 16'hA001;
	localparam logic [15:0] CCITT_POLY = 16'h8408;
	localparam logic [1:0] EV_TX_CHAR = 2'h0;
	localparam logic [1:0] EV_RX_CHAR = 2'h1;
	localparam logic [1:0] EV_TX_CHECK = 2'h2;
	localparam logic [1:0] EV_TX_ERROR = 2'h3;
	localparam logic [1:0] TS_PRI_DONE = 2'h1;
	localparam logic [1:0] TS_ALT_DONE = 2'h2;
	localparam logic [7:0] RIC_COUNT_ZERO = 8'h01;
	typedef struct packed {
		logic [1:0]  kind;
		logic [3:0]  line;
		logic [7:0]  data;
		logic [7:0]  ctrl;
		logic [15:0] lineState;
		logic [15:0] protoParam;
		logic [15:0] progress;
	} event_t;
	typedef struct packed {
		logic       valid;
		logic [3:0] line;
		logic [1:0] code;
		logic       resume;
	} status_t;
	typedef struct packed {
		logic       valid;
		logic [3:0] line;
		logic [7:0] code;
	} ric_t;
	typedef struct packed {
		logic       valid;
		logic       rx;
		logic [3:0] line;
		logic [2:0] mode;
		logic       check;
	} mode_t;
	typedef struct packed {
		logic       valid;
		logic [3:0] line;
		logic [7:0] value;
	} check_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND_HI = 2'b10
	} state_t;
endpackage
`default_nettype wire

// ==== line_transfer_state_ram.sv ====
`timescale 1ns/10ps
`default_nettype none

module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,    // System clock
	input  wire logic             resetn,   // Synchronous reset
	input  wire logic             inValid,  // Write request
	output logic                  inReady,  // Room available
	input  wire logic [WIDTH-1:0] inData,   // Write data
	output logic                  outValid, // Data available
	input  wire logic             outReady, // Read accept
	output logic [WIDTH-1:0]      outData   // Head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic [AW:0]      count_nxt;
	// Full flag kept in a flop so inReady is registered
	logic             notFull_r;
	wire              push = inValid && notFull_r;
	wire              pop = outReady && (count_r != '0);

	assign inReady = notFull_r;
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];
	assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			notFull_r <= 1'b1;
		end else begin
			wrPtr_r <= wrPtr_r + AW'(push);
			rdPtr_r <= rdPtr_r + AW'(pop);
			count_r <= count_nxt;
			notFull_r <= (count_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule

module line_transfer_state_ram (
	input  wire logic                 clock,       // 40 MHz clock
	input  wire logic                 resetn,      // Synchronous reset, active low
	input  wire logic                 selWr,       // Load select register
	input  wire logic [7:0]           selData,     // Line [7:4], word [3:0]
	input  wire logic                 accWr,       // Write access register
	input  wire logic                 accRd,       // Read access register
	input  wire logic [15:0]          accWrData,   // Access write data
	output logic [15:0]               accRdData,   // Access read data
	output logic                      accRdValid,  // Read data strobe
	input  wire logic [15:0]          scrValue,    // Secondary control register
	input  wire logic                 evValid,     // Character event offered
	output logic                      evReady,     // Event queue has room
	input  wire line_xfer_pkg::event_t evData,     // Character event
	output logic                      memAddrValid, // Character memory address strobe
	output logic [17:0]               memAddr,     // Character memory address
	output logic [3:0]                memLine,     // Line of that character
	output line_xfer_pkg::status_t    txStatus,    // Transfer status post
	output line_xfer_pkg::ric_t       rxInt,       // Receive interrupt code post
	output line_xfer_pkg::ric_t       goClear,     // Transmitter go clear request
	output line_xfer_pkg::mode_t      modeChange,  // Mode change request
	output line_xfer_pkg::check_t     checkOut     // Block check byte to send
);
	logic [15:0]                 ram [0:line_xfer_pkg::WORDS-1];
	// Two hidden extension bits ride beside every word
	logic [1:0]                  extMem [0:line_xfer_pkg::WORDS-1];
	logic [7:0]                  sel_r;
	line_xfer_pkg::state_t       state_r;
	line_xfer_pkg::state_t       state_nxt;
	logic [7:0]                  hiByte_r;
	logic [3:0]                  hiLine_r;
	line_xfer_pkg::event_t       ev;
	logic                        fifoValid;
	logic [15:0]                 accRdData_r;
	logic                        accRdValid_r;
	logic                        memAddrValid_r;
	logic [17:0]                 memAddr_r;
	logic [3:0]                  memLine_r;
	line_xfer_pkg::status_t      txStatus_r;
	line_xfer_pkg::ric_t         rxInt_r;
	line_xfer_pkg::ric_t         goClear_r;
	line_xfer_pkg::mode_t        modeChange_r;
	line_xfer_pkg::check_t       checkOut_r;

	// LRC folds into the low byte; CRCs shift a whole byte per step
	function automatic logic [15:0] chkNext(input logic [15:0] acc, input logic [7:0] d,
		input logic [1:0] t);
		logic [15:0] c;
		logic [15:0] poly;
		c = acc ^ {8'h00, d};
		poly = (t == line_xfer_pkg::CHK_CCITT) ? line_xfer_pkg::CCITT_POLY
			: line_xfer_pkg::CRC16_POLY;
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ poly) : (c >> 1);
		end
		case (t)
			line_xfer_pkg::CHK_LRC: chkNext = {acc[15:8], acc[7:0] ^ d};
			line_xfer_pkg::CHK_CRC16: chkNext = c;
			line_xfer_pkg::CHK_CCITT: chkNext = c;
			default: chkNext = acc;
		endcase
	endfunction

	wire stIdle = (state_r == line_xfer_pkg::ST_IDLE);
	wire take = fifoValid && stIdle && !accWr;

	sync_fifo #(
		.WIDTH($bits(line_xfer_pkg::event_t)),
		.DEPTH(line_xfer_pkg::FIFO_DEPTH)
	) eventQueue (
		.clock(clock),
		.resetn(resetn),
		.inValid(evValid),
		.inReady(evReady),
		.inData(evData),
		.outValid(fifoValid),
		.outReady(take),
		.outData(ev)
	);

	wire [7:0] selAddr = sel_r;
	wire isTx = (ev.kind == line_xfer_pkg::EV_TX_CHAR);
	wire isRx = (ev.kind == line_xfer_pkg::EV_RX_CHAR);
	wire isChk = (ev.kind == line_xfer_pkg::EV_TX_CHECK);
	wire isErr = (ev.kind == line_xfer_pkg::EV_TX_ERROR);
	wire useAlt = ev.lineState[line_xfer_pkg::LS_ALT_BIT];
	wire goSet = ev.lineState[line_xfer_pkg::LS_GO_BIT];
	wire [1:0] chkType = ev.protoParam[line_xfer_pkg::PP_TYPE_LO +: 2];
	wire inCheck = ev.ctrl[line_xfer_pkg::CTRL_CHECK_BIT];
	wire isLrc = (chkType == line_xfer_pkg::CHK_LRC);
	wire [7:0] aTxAddr = {ev.line, useAlt ? line_xfer_pkg::REG_TXA_ADDR : line_xfer_pkg::REG_TXP_ADDR};
	wire [7:0] aTxCnt = {ev.line, useAlt ? line_xfer_pkg::REG_TXA_CNT : line_xfer_pkg::REG_TXP_CNT};
	wire [7:0] aTxOther = {ev.line, useAlt ? line_xfer_pkg::REG_TXP_CNT : line_xfer_pkg::REG_TXA_CNT};
	wire [7:0] aRxAddr = {ev.line, line_xfer_pkg::REG_RX_ADDR};
	wire [7:0] aRxCnt = {ev.line, line_xfer_pkg::REG_RX_CNT};
	wire [7:0] aTxAcc = {ev.line, line_xfer_pkg::REG_TX_ACC};
	wire [7:0] aRxAcc = {ev.line, line_xfer_pkg::REG_RX_ACC};
	wire [17:0] txAddr = {extMem[aTxAddr], ram[aTxAddr]};
	wire [17:0] rxAddr = {extMem[aRxAddr], ram[aRxAddr]};
	wire [17:0] txNextAddr = txAddr + 18'h00001;
	wire [17:0] rxNextAddr = rxAddr + 18'h00001;
	wire [15:0] txCnt = ram[aTxCnt];
	wire [15:0] rxCnt = ram[aRxCnt];
	wire [14:0] txNextCnt = txCnt[14:0] + 15'h0001;
	wire [14:0] rxNextCnt = rxCnt[14:0] + 15'h0001;
	wire txZero = (txNextCnt == 15'h0000);
	wire rxZero = (rxNextCnt == 15'h0000);
	wire txBoth = txZero && (ram[aTxOther][14:0] == 15'h0000);
	wire rxStopped = (rxCnt[14:0] == 15'h0000);
	wire txMarked = !txCnt[line_xfer_pkg::MARK_BIT];
	wire rxMarked = !rxCnt[line_xfer_pkg::MARK_BIT];
	wire [15:0] txAcc = ram[aTxAcc];
	wire [15:0] rxAcc = ram[aRxAcc];
	wire [15:0] txAccNext = inCheck ? chkNext(txAcc, ev.data, chkType) : txAcc;
	wire [15:0] rxAccNext = inCheck ? chkNext(rxAcc, ev.data, chkType) : rxAcc;
	wire rxStore = isRx && !rxStopped;

	// Host writes win; an event waits in the queue that cycle
	always_ff @(posedge clock) begin
		if (accWr) begin
			ram[selAddr] <= accWrData;
			extMem[selAddr] <= scrValue[line_xfer_pkg::SCR_EXT_LO +: 2];
		end else if (take && isTx) begin
			ram[aTxAddr] <= txNextAddr[15:0];
			extMem[aTxAddr] <= txNextAddr[17:16];
			ram[aTxCnt] <= {txCnt[line_xfer_pkg::MARK_BIT], txNextCnt};
			ram[aTxAcc] <= txAccNext;
		end else if (take && rxStore) begin
			ram[aRxAddr] <= rxNextAddr[15:0];
			extMem[aRxAddr] <= rxNextAddr[17:16];
			ram[aRxCnt] <= {rxCnt[line_xfer_pkg::MARK_BIT], rxNextCnt};
			ram[aRxAcc] <= rxAccNext;
		end else if (take && isChk) begin
			ram[aTxAcc] <= 16'h0000;
		end
	end

	// A two-byte check holds the queue for one extra cycle
	always_comb begin
		state_nxt = line_xfer_pkg::ST_IDLE;
		case (state_r)
			line_xfer_pkg::ST_IDLE: begin
				if (take && isChk && !isLrc) begin
					state_nxt = line_xfer_pkg::ST_SEND_HI;
				end
			end
			line_xfer_pkg::ST_SEND_HI: state_nxt = line_xfer_pkg::ST_IDLE;
			default: state_nxt = line_xfer_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			sel_r <= 8'h00;
			state_r <= line_xfer_pkg::ST_IDLE;
			hiByte_r <= 8'h00;
			hiLine_r <= 4'h0;
		end else begin
			if (selWr) begin
				sel_r <= selData;
			end
			state_r <= state_nxt;
			if (take && isChk) begin
				hiByte_r <= txAcc[15:8];
				hiLine_r <= ev.line;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			accRdData_r <= 16'h0000;
			accRdValid_r <= 1'b0;
			memAddrValid_r <= 1'b0;
			memAddr_r <= 18'h00000;
			memLine_r <= 4'h0;
		end else begin
			accRdValid_r <= accRd;
			if (accRd) begin
				accRdData_r <= ram[selAddr];
			end
			memAddrValid_r <= take && (isTx || rxStore);
			memAddr_r <= isTx ? txAddr : rxAddr;
			memLine_r <= ev.line;
		end
	end

	// Per-event result pulses, one cycle each
	always_ff @(posedge clock) begin
		if (!resetn) begin
			txStatus_r <= '0;
			rxInt_r <= '0;
			goClear_r <= '0;
			modeChange_r <= '0;
		end else begin
			txStatus_r.valid <= take && isTx && txZero;
			txStatus_r.line <= ev.line;
			txStatus_r.code <= useAlt ? line_xfer_pkg::TS_ALT_DONE : line_xfer_pkg::TS_PRI_DONE;
			txStatus_r.resume <= goSet && !txBoth;
			rxInt_r.valid <= take && rxStore && rxZero;
			rxInt_r.line <= ev.line;
			rxInt_r.code <= line_xfer_pkg::RIC_COUNT_ZERO;
			goClear_r.valid <= take && ((isTx && txBoth) || isErr);
			goClear_r.line <= ev.line;
			goClear_r.code <= 8'h00;
			modeChange_r.valid <= take && ((isTx && txZero && txMarked)
				|| (rxStore && rxZero && rxMarked));
			modeChange_r.rx <= isRx;
			modeChange_r.line <= ev.line;
			modeChange_r.mode <= isRx ? ev.lineState[line_xfer_pkg::LS_MODE_LO +: 3]
				: ev.progress[line_xfer_pkg::LP_MODE_LO +: 3];
			modeChange_r.check <= isRx ? ev.lineState[line_xfer_pkg::LS_CHECK_BIT]
				: ev.progress[line_xfer_pkg::LP_CHECK_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			checkOut_r <= '0;
		end else if (!stIdle) begin
			checkOut_r <= {1'b1, hiLine_r, hiByte_r};
		end else begin
			checkOut_r <= {take && isChk, ev.line, txAcc[7:0]};
		end
	end

	assign accRdData = accRdData_r;
	assign accRdValid = accRdValid_r;
	assign memAddrValid = memAddrValid_r;
	assign memAddr = memAddr_r;
	assign memLine = memLine_r;
	assign txStatus = txStatus_r;
	assign rxInt = rxInt_r;
	assign goClear = goClear_r;
	assign modeChange = modeChange_r;
	assign checkOut = checkOut_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// RAM update, status, go clear, mode change and check output guards
	txAddrStep_a: assert property (take && isTx |=> ram[$past(aTxAddr)] == $past(txNextAddr[15:0]))
		else $error("transmit address did not step");
	markKept_a: assert property (take && isTx
		|=> ram[$past(aTxCnt)][line_xfer_pkg::MARK_BIT] == $past(txCnt[line_xfer_pkg::MARK_BIT]))
		else $error("mark flag changed while counting");
	txZeroPost_a: assert property (take && isTx && txZero |=> txStatus.valid
		&& txStatus.code == ($past(useAlt) ? line_xfer_pkg::TS_ALT_DONE
		: line_xfer_pkg::TS_PRI_DONE))
		else $error("count zero status wrong");
	goClearBoth_a: assert property (take && isTx && txBoth |=> goClear.valid)
		else $error("go not cleared on both counts zero");
	rxStopStore_a: assert property (take && isRx && rxStopped |=> !memAddrValid && !rxInt.valid)
		else $error("character stored after receive count zero");
	checkClear_a: assert property (take && isChk |=> ram[$past(aTxAcc)] == 16'h0000)
		else $error("transmit check not cleared");
	checkTwo_a: assert property (take && isChk && !isLrc |=> checkOut.valid ##1 checkOut.valid)
		else $error("two byte check not sent");
	checkLrc_a: assert property (take && isChk && isLrc |=> checkOut.valid && stIdle)
		else $error("LRC check not single byte");
	txModeSel_a: assert property (take && isTx && txZero && txMarked
		|=> modeChange.valid
		&& modeChange.mode == $past(ev.progress[line_xfer_pkg::LP_MODE_LO +: 3]))
		else $error("marked transmit mode change wrong");
	rxCheckHold_a: assert property (take && rxStore && !inCheck
		|=> ram[$past(aRxAcc)] == $past(rxAcc))
		else $error("receive check changed for excluded character");

	// Receive, exclusion, error and extension capture guards
	rxModeSel_a: assert property (take && rxStore && rxZero && rxMarked
		|=> modeChange.valid && modeChange.rx
		&& modeChange.mode == $past(ev.lineState[line_xfer_pkg::LS_MODE_LO +: 3]))
		else $error("marked receive mode change wrong");
	rxIntPost_a: assert property (take && rxStore && rxZero
		|=> rxInt.valid && rxInt.code == line_xfer_pkg::RIC_COUNT_ZERO)
		else $error("receive count zero not posted");
	txCheckHold_a: assert property (take && isTx && !inCheck
		|=> ram[$past(aTxAcc)] == $past(txAcc))
		else $error("transmit check changed for excluded character");
	goClearErr_a: assert property (take && isErr |=> goClear.valid)
		else $error("go not cleared on memory error");
	extCapture_a: assert property (accWr
		|=> extMem[$past(selAddr)] == $past(scrValue[line_xfer_pkg::SCR_EXT_LO +: 2]))
		else $error("extension bits not captured");

	// Scenario covers
	txZeroSeen_c: cover property (take && isTx && txZero && goSet);
	checkPair_c: cover property (take && isChk && !isLrc ##1 checkOut.valid);
	rxStop_c: cover property (take && isRx && rxStopped);
	queueFull_c: cover property (!evReady);
	rxMark_c: cover property (take && rxStore && rxZero && rxMarked);
endmodule
`default_nettype wire

// ==== char_source_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module char_source_model (
	input  wire logic             clock,   // System clock
	input  wire logic             resetn,  // Synchronous reset, active low
	input  wire logic             evReady, // Queue has room
	output logic                  evValid, // Event offered
	output line_xfer_pkg::event_t evData   // Event contents
);
	// Holds the event until taken, then scrambles the released bus
	task automatic offer(input line_xfer_pkg::event_t ev, input int stall);
		repeat (stall) @(posedge clock);
		evValid <= 1'b1;
		evData <= ev;
		do @(posedge clock); while (evReady !== 1'b1 || resetn !== 1'b1);
		evValid <= 1'b0;
		evData <= ~ev;
	endtask

	initial begin
		evValid = 1'b0;
		evData = '0;
	end
endmodule
`default_nettype wire

// ==== tb_line_transfer_state_ram.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_line_transfer_state_ram;
	logic                          clock = 1'b0, resetn = 1'b0, selWr = 1'b0;
	logic                          accWr = 1'b0, accRd = 1'b0;
	logic                          evValid, evReady, accRdValid, memAddrValid, sawFull;
	logic [7:0]                    selData = 8'h00, b;
	logic [15:0]                   accWrData = 16'h0000, scrValue = 16'h0000, accRdData, d, r;
	logic [17:0]                   memAddr, lastAddr;
	logic [3:0]                    memLine, lastLine;
	line_xfer_pkg::event_t         evData;
	line_xfer_pkg::status_t        txStatus, lastSt;
	line_xfer_pkg::ric_t           rxInt, goClear, lastRic;
	line_xfer_pkg::mode_t          modeChange, lastMode;
	line_xfer_pkg::check_t         checkOut;
	logic [7:0]                    chk[$];
	int                            errors = 0, tests_run = 0, mem = 0, st = 0, receive_interrupt_character_register = 0, go = 0;
	int                            md = 0, m0;

	line_transfer_state_ram u_line_transfer_state_ram (.clock(clock), .resetn(resetn),
		.selWr(selWr), .selData(selData), .accWr(accWr), .accRd(accRd),
		.accWrData(accWrData), .accRdData(accRdData), .accRdValid(accRdValid),
		.scrValue(scrValue), .evValid(evValid), .evReady(evReady), .evData(evData),
		.memAddrValid(memAddrValid), .memAddr(memAddr), .memLine(memLine),
		.txStatus(txStatus), .rxInt(rxInt), .goClear(goClear), .modeChange(modeChange),
		.checkOut(checkOut));
	char_source_model u_char_source_model (.clock(clock), .resetn(resetn),
		.evReady(evReady), .evValid(evValid), .evData(evData));

	always #12.5 clock = ~clock;

	// Records the one-cycle output pulses
	always @(posedge clock) begin
		if (memAddrValid === 1'b1) begin mem++; lastAddr = memAddr; lastLine = memLine; end
		if (txStatus.valid === 1'b1) begin st++; lastSt = txStatus; end
		if (rxInt.valid === 1'b1) begin receive_interrupt_character_register++; lastRic = rxInt; end
		if (goClear.valid === 1'b1) go++;
		if (modeChange.valid === 1'b1) begin md++; lastMode = modeChange; end
		if (checkOut.valid === 1'b1) chk.push_back(checkOut.value);
		if (evReady === 1'b0) sawFull = 1'b1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, seen, exp);
		end
	endtask

	task automatic final_report;
		if (errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic sel(input logic [3:0] l, input logic [3:0] w);
		@(posedge clock);
		selWr <= 1'b1;
		selData <= {l, w};
		@(posedge clock);
		selWr <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] l, w, input logic [15:0] v, input logic [1:0] e);
		sel(l, w);
		accWr <= 1'b1;
		accWrData <= v;
		scrValue <= {10'h000, e, 4'h0};
		@(posedge clock);
		accWr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] l, w, output logic [15:0] v);
		sel(l, w);
		accRd <= 1'b1;
		@(posedge clock);
		accRd <= 1'b0;
		#1;
		check(accRdValid, 1'b1, "read strobe");
		v = accRdData;
	endtask

	task automatic ev(input logic [1:0] k, input logic [3:0] l, input logic [7:0] c, ct,
		input logic [15:0] ls, pp, pr);
		u_char_source_model.offer({k, l, c, ct, ls, pp, pr}, $urandom_range(3, 0));
		repeat (5) @(posedge clock);
	endtask

	function automatic logic [15:0] step(input logic [15:0] a, input logic [7:0] c,
		input logic [1:0] t);
		logic [15:0] x;
		x = a ^ {8'h00, c};
		if (t == line_xfer_pkg::CHK_LRC) return x;
		if (t == 2'h2) return a;
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? (x >> 1) ^ (t == line_xfer_pkg::CHK_CRC16 ?
				line_xfer_pkg::CRC16_POLY : line_xfer_pkg::CCITT_POLY) : x >> 1;
		end
		return x;
	endfunction

	initial begin
		#(25 * 20000);
		errors++;
		final_report();
	end

	initial begin
		m0 = $urandom(32'h0AB30BE2);
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			r = $urandom;
			m0 = $urandom_range(255, 0);
			wr(m0[7:4], m0[3:0], r, 2'h0);
			rd(m0[7:4], m0[3:0], d);
			check(d, r, "word readback");
		end
		wr(4'h5, 4'h9, 16'hA5C3, 2'h0);
		@(posedge clock);
		resetn <= 1'b0;
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		rd(4'h5, 4'h9, d);
		check(d, 16'hA5C3, "kept over reset");
		wr(4'h3, 4'h8, 16'h2468, 2'h1);
		wr(4'h3, 4'h9, 16'h1357, 2'h2);
		rd(4'h3, 4'h8, d);
		check(d, 16'h2468, "tx table base");
		rd(4'h3, 4'h9, d);
		check(d, 16'h1357, "rx table base");
		wr(4'h3, 4'h0, 16'h1234, 2'h2);
		wr(4'h3, 4'h1, 16'h7FFE, 2'h0);
		wr(4'h3, 4'h2, 16'h4000, 2'h1);
		wr(4'h3, 4'h3, 16'hFFFF, 2'h0);
		ev(2'h0, 4'h3, 8'h41, 8'h00, 16'h0004, 16'h0000, 16'hA400);
		check(lastAddr, {2'h2, 16'h1234}, "principal address");
		rd(4'h3, 4'h0, d);
		check(d, 16'h1235, "principal step");
		rd(4'h3, 4'h1, d);
		check(d, 16'h7FFF, "count step");
		ev(2'h0, 4'h3, 8'h42, 8'h00, 16'h0004, 16'h0000, 16'hA400);
		check(lastSt, {1'b1, 4'h3, line_xfer_pkg::TS_PRI_DONE, 1'b1}, "pri done");
		check(lastMode, {1'b1, 1'b0, 4'h3, 3'h5, 1'b1}, "tx mode");
		rd(4'h3, 4'h1, d);
		check(d, 16'h0000, "mark kept");
		m0 = md;
		ev(2'h0, 4'h3, 8'h43, 8'h00, 16'h0084, 16'h0000, 16'hA400);
		check(lastAddr, {2'h1, 16'h4000}, "alternate address");
		check(lastSt, {1'b1, 4'h3, line_xfer_pkg::TS_ALT_DONE, 1'b0}, "alt done");
		check(go, 1, "go clear both zero");
		check(md, m0, "unmarked no mode");
		ev(2'h3, 4'h3, 8'h00, 8'h00, 16'h0004, 16'h0000, 16'h0000);
		check(go, 2, "go clear error");
		for (int t = 0; t < 4; t++) begin
			r = $urandom;
			b = 8'($urandom);
			wr(4'h6, 4'h6, r, 2'h0);
			wr(4'h6, 4'h1, 16'hC000, 2'h0);
			wr(4'h6, 4'h7, r, 2'h0);
			wr(4'h6, 4'h5, 16'hC000, 2'h0);
			ev(2'h0, 4'h6, b, 8'h08, 16'h0004, {11'h000, t[1:0], 3'h0}, 16'h0000);
			ev(2'h1, 4'h6, b, {4'h0, t[0], 3'h0}, 16'h0004, {11'h000, t[1:0], 3'h0},
				16'h0000);
			rd(4'h6, 4'h7, d);
			check(d, t[0] ? step(r, b, t[1:0]) : r, "rx check");
			rd(4'h6, 4'h6, d);
			check(d, step(r, b, t[1:0]), "acc read");
			chk.delete();
			ev(2'h2, 4'h6, 8'h00, 8'h00, 16'h0004, {11'h000, t[1:0], 3'h0}, 16'h0000);
			check(chk.size(), t == 0 ? 1 : 2, "check bytes");
			check(chk[0], d[7:0], "low byte first");
			if (t != 0) check(chk[1], d[15:8], "high byte");
			rd(4'h6, 4'h6, d);
			check(d, 16'h0000, "acc cleared");
		end
		wr(4'h7, 4'h4, 16'h0100, 2'h3);
		wr(4'h7, 4'h5, 16'h7FFF, 2'h0);
		ev(2'h1, 4'h7, 8'h55, 8'h00, 16'hC400, 16'h0000, 16'h0000);
		check(lastAddr, {2'h3, 16'h0100}, "rx address");
		check(lastLine, 4'h7, "rx line");
		check(lastRic, {1'b1, 4'h7, line_xfer_pkg::RIC_COUNT_ZERO}, "rx int");
		check(lastMode, {1'b1, 1'b1, 4'h7, 3'h6, 1'b1}, "rx mode");
		m0 = mem;
		ev(2'h1, 4'h7, 8'h56, 8'h00, 16'hC400, 16'h0000, 16'h0000);
		check(mem, m0, "rx stopped");
		wr(4'h2, 4'h4, 16'h0000, 2'h0);
		wr(4'h2, 4'h5, 16'hC000, 2'h0);
		sawFull = 1'b0;
		m0 = mem;
		fork
			begin
				sel(4'h2, 4'hF);
				accWr <= 1'b1;
				repeat (40) @(posedge clock);
				accWr <= 1'b0;
			end
			repeat (17) u_char_source_model.offer({2'h1, 4'h2, 16'h0000, 48'h0}, 1);
		join
		repeat (20) @(posedge clock);
		check(sawFull, 1'b1, "queue refused");
		check(mem - m0, 17, "all drained");
		rd(4'h2, 4'h4, d);
		check(d, 16'h0011, "rx address steps");
		final_report();
	end
endmodule
`default_nettype wire
